// >>> mmnp_master_model.sv
// cpu, dma and programmer port model facing the block
`timescale 1ns/1ns
module mmnp_master_model (
  input wire logic ref_clk,
  input wire logic [mmnp_pkg::NMAST-1:0] mstStall,
  input wire logic [7:0] pdiRdata,
  output mmnp_pkg::mmnp_req_type [mmnp_pkg::NMAST-1:0] mstReq,
  output mmnp_pkg::mmnp_pdi_type pdiReq
);
  import mmnp_pkg::*;
  int stallCnt [NMAST];
  initial begin
    mstReq = '0;
    pdiReq = '0;
    foreach (stallCnt[i]) stallCnt[i] = 0;
  end
  // lost request is held unchanged and retried, never dropped
  task automatic req(input int m, input mmnp_op_type op,
      input logic [15:0] a, input logic w, input logic [2:0] b);
    @(posedge ref_clk);
    mstReq[m] <= '{valid: 1'b1, write: w, op: op, addr: a,
      wdata: 8'h5a, bitIdx: b};
    @(negedge ref_clk);
    while (mstStall[m] === 1'b1) begin
      stallCnt[m]++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    // released lines other than op show junk, not the last value
    mstReq[m] <= '{valid: 1'b0, write: ~w, op: op, addr: ~a,
      wdata: 8'ha5, bitIdx: ~b};
  endtask
  task automatic programming_debug_port(input mmnp_sel_type s, input logic w,
      input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    pdiReq <= '{valid: 1'b1, write: w, sel: s, addr: a, wdata: d};
    @(posedge ref_clk);
    pdiReq <= '{valid: 1'b0, write: ~w, sel: s, addr: ~a, wdata: ~d};
    @(negedge ref_clk);
    q = pdiRdata;
  endtask
endmodule // mmnp_master_model

// >>> mmnp_pkg.sv
// shared constants and types for the memory map and nvm protection block
package mmnp_pkg;
  // flash: 16-bit locations, word addressed, largest variant
  localparam int FW_W = 16;
  localparam int FA_W = 17;
  localparam logic [FA_W-1:0] APPTBL_START = 17'h0f000;
  localparam logic [FA_W-1:0] BOOT_START = 17'h10000;
  localparam logic [FA_W-1:0] BOOT_END = 17'h10fff;
  localparam logic [9:0] FLASH_PAGES = 10'h220;
  localparam int PAGE_LOG = 7;
  // data space
  localparam logic [15:0] GPIO_END = 16'h000f;
  localparam logic [15:0] BITIO_END = 16'h001f;
  localparam logic [15:0] SHORTIO_END = 16'h003f;
  localparam logic [15:0] EXTIO_START = 16'h0040;
  localparam logic [15:0] IO_END = 16'h0fff;
  localparam logic [15:0] EE_START = 16'h1000;
  localparam logic [15:0] EE_END = 16'h1fff;
  localparam logic [15:0] SRAM_START = 16'h2000;
  // register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LOCK = 4'h1;
  localparam logic [3:0] REG_FUSE = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_SIGADR = 4'h4;
  localparam logic [3:0] REG_PSIG = 4'h5;
  localparam logic [3:0] REG_USIG = 4'h6;
  localparam logic [3:0] REG_CMD = 4'h7;
  localparam int CTRL_EEMAP = 0;
  localparam int CMD_CHIPERASE = 0;
  localparam int CMD_USIGERASE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  // write-protect bit of each lock group, zero means programmed
  localparam int LOCK_APP = 0;
  localparam int LOCK_TBL = 2;
  localparam int LOCK_BOOT = 4;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] FUSE_RST = 8'hff;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  // production signature row layout
  localparam logic [7:0] PS_CAL = 8'h00;
  localparam logic [7:0] PS_ID = 8'h08;
  localparam logic [7:0] PS_LOT = 8'h10;
  localparam logic [7:0] PS_WAFER = 8'h16;
  localparam logic [7:0] PS_XY = 8'h18;
  localparam int CAL_N = 4;
  localparam int USIG_BYTES = 256;
  localparam int NMAST = 3;
  localparam int NSET = 3;
  localparam int M_CPU = 0;
  localparam int M_DRD = 1;
  localparam int M_DWR = 2;

  typedef enum logic [1:0] {OP_DATA, OP_IO, OP_BITSET, OP_BITCLR} mmnp_op_type;
  typedef enum logic [1:0] {SET_IO, SET_EE, SET_SRAM, SET_NONE} mmnp_set_type;
  typedef enum logic [2:0] {SEL_FUSE, SEL_LOCK, SEL_USIG, SEL_PSIG,
    SEL_ERASE} mmnp_sel_type;
  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_ERASE, ST_LOCKCLR}
    mmnp_fsm_type;

  typedef struct packed {
    logic valid;
    logic write;
    mmnp_op_type op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitIdx;
  } mmnp_req_type;

  typedef struct packed {
    logic valid;
    logic write;
    mmnp_op_type op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitIdx;
    logic [1:0] master;
  } mmnp_bus_type;

  typedef struct packed {
    logic valid;
    logic write;
    mmnp_sel_type sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmnp_pdi_type;

  typedef struct packed {
    logic valid;
    logic [FA_W-1:0] pc;
    logic [FA_W-1:0] addr;
    logic [FW_W-1:0] data;
  } mmnp_spm_type;

  typedef struct packed {
    logic wr;
    logic pageErase;
    logic [FA_W-1:0] addr;
    logic [FW_W-1:0] data;
  } mmnp_flash_type;

  typedef struct packed {
    mmnp_fsm_type fsm;
    logic [9:0] cnt;
    logic eeMap;
    logic [7:0] lock;
    logic [7:0] fuse;
    logic [7:0] sigAdr;
    logic refused;
    logic [7:0] rdata;
    logic [7:0] pdiRdata;
    logic [CAL_N-1:0][7:0] cal;
    logic calDone;
    logic [15:0][7:0] gpio;
    logic [USIG_BYTES-1:0][7:0] usig;
    mmnp_flash_type flash;
    mmnp_bus_type [NSET-1:0] bus;
    logic [NMAST-1:0][7:0] gpRd;
    logic [NMAST-1:0] gpHit;
    logic [NMAST-1:0] decErr;
  } mmnp_state_type;

  localparam mmnp_state_type ST_RST = '{fsm: ST_CAL, lock: LOCK_RST,
    fuse: FUSE_RST, usig: '1, default: '0};
endpackage

// >>> mmnp_top.sv
// memory map decode, bus arbitration and nvm protection
`timescale 1ns/1ns
module mmnp_top #(
  parameter logic [23:0] DEV_ID = 24'h5a3c01, // arbitrary value
  parameter logic [47:0] LOT_NUM = 48'h0102030405a6, // arbitrary value
  parameter logic [7:0] WAFER_NUM = 8'h07, // arbitrary value
  parameter logic [31:0] WAFER_XY = 32'h00110022, // arbitrary value
  parameter logic [mmnp_pkg::CAL_N*8-1:0] CAL_BYTES = 32'h80402010 // arbitrary
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire mmnp_pkg::mmnp_req_type [mmnp_pkg::NMAST-1:0] mstReq,
  output logic [mmnp_pkg::NMAST-1:0] mstStall,
  output logic [mmnp_pkg::NMAST-1:0] mstGpHit,
  output logic [mmnp_pkg::NMAST-1:0][7:0] mstGpRdata,
  output logic [mmnp_pkg::NMAST-1:0] mstDecErr,
  output mmnp_pkg::mmnp_bus_type [mmnp_pkg::NSET-1:0] setBus,
  input wire mmnp_pkg::mmnp_spm_type spmReq,
  output mmnp_pkg::mmnp_flash_type flashOut,
  input wire mmnp_pkg::mmnp_pdi_type pdiReq,
  output logic [7:0] pdiRdata,
  output logic [7:0] lockBits,
  output logic [7:0] fuseBits,
  output logic [mmnp_pkg::CAL_N-1:0][7:0] calOut,
  output logic calDone
);
  import mmnp_pkg::*;

  mmnp_state_type st_r;
  mmnp_state_type st_nxt;
  mmnp_set_type [NMAST-1:0] setSel;
  logic [NMAST-1:0][15:0] effAddr;
  logic [NMAST-1:0] grant;

  // id and serial are fixed constants, so no write path can reach them
  function automatic logic [7:0] psigByte(input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a >= PS_CAL && a < PS_CAL + 8'(CAL_N))
      b = CAL_BYTES[8*(a-PS_CAL) +: 8];
    else if (a >= PS_ID && a < PS_ID + 8'h03)
      b = DEV_ID[8*(a-PS_ID) +: 8];
    else if (a >= PS_LOT && a < PS_LOT + 8'h06)
      b = LOT_NUM[8*(a-PS_LOT) +: 8];
    else if (a == PS_WAFER)
      b = WAFER_NUM;
    else if (a >= PS_XY && a < PS_XY + 8'h04)
      b = WAFER_XY[8*(a-PS_XY) +: 8];
    return b;
  endfunction

  function automatic logic inBoot(input logic [FA_W-1:0] a);
    return a >= BOOT_START && a <= BOOT_END;
  endfunction

  // lock bits are active low: programmed (0) blocks writes
  function automatic logic flashWritable(input logic [FA_W-1:0] a,
      input logic [7:0] lk);
    logic ok;
    ok = 1'b0;
    if (inBoot(a))
      ok = lk[LOCK_BOOT];
    else if (a >= APPTBL_START && a < BOOT_START)
      ok = lk[LOCK_TBL];
    else if (a < APPTBL_START)
      ok = lk[LOCK_APP];
    return ok;
  endfunction

  // decode per master; start addresses are constants for every variant
  always_comb begin
    for (int m = 0; m < NMAST; m++) begin
      case (mstReq[m].op)
        OP_IO: effAddr[m] = {10'h000, mstReq[m].addr[5:0]};
        OP_BITSET, OP_BITCLR:
          effAddr[m] = {11'h000, mstReq[m].addr[4:0]};
        default: effAddr[m] = mstReq[m].addr;
      endcase
      if (effAddr[m] <= IO_END)
        setSel[m] = SET_IO;
      else if (effAddr[m] >= EE_START && effAddr[m] <= EE_END)
        setSel[m] = st_r.eeMap ? SET_EE : SET_NONE;
      else if (effAddr[m] >= SRAM_START)
        setSel[m] = SET_SRAM;
      else
        setSel[m] = SET_NONE;
    end
  end

  // lower master index wins; cpu first, then dma read, then dma write
  always_comb begin
    logic [NSET-1:0] taken;
    taken = '0;
    grant = '0;
    for (int m = 0; m < NMAST; m++) begin
      if (mstReq[m].valid && setSel[m] != SET_NONE &&
          !taken[setSel[m]]) begin
        grant[m] = 1'b1;
        taken[setSel[m]] = 1'b1;
      end
    end
  end

  always_comb begin
    logic gpAcc;
    logic [3:0] gi;
    logic [7:0] cur;
    logic [7:0] regRdNxt;
    gpAcc = 1'b0;
    gi = 4'h0;
    cur = 8'h00;
    regRdNxt = 8'h00;
    st_nxt = st_r;
    st_nxt.flash.wr = 1'b0;
    st_nxt.flash.pageErase = 1'b0;
    st_nxt.gpHit = '0;
    st_nxt.decErr = '0;
    for (int s = 0; s < NSET; s++)
      st_nxt.bus[s].valid = 1'b0;

    // data-space accesses; gpio handled here, rest goes to its own bus
    for (int m = 0; m < NMAST; m++) begin
      if (mstReq[m].valid && setSel[m] == SET_NONE)
        st_nxt.decErr[m] = 1'b1;
      gpAcc = grant[m] && setSel[m] == SET_IO && effAddr[m] <= GPIO_END;
      gi = effAddr[m][3:0];
      cur = st_r.gpio[gi];
      if (gpAcc) begin
        st_nxt.gpHit[m] = 1'b1;
        st_nxt.gpRd[m] = cur;
        case (mstReq[m].op)
          OP_BITSET: st_nxt.gpio[gi] = cur | (8'h01 << mstReq[m].bitIdx);
          OP_BITCLR: st_nxt.gpio[gi] = cur & ~(8'h01 << mstReq[m].bitIdx);
          default: if (mstReq[m].write) st_nxt.gpio[gi] = mstReq[m].wdata;
        endcase
      end else if (grant[m]) begin
        // eeprom writes through the window are page-buffer loads
        st_nxt.bus[setSel[m]] = '{valid: 1'b1, write: mstReq[m].write,
          op: mstReq[m].op, addr: effAddr[m], wdata: mstReq[m].wdata,
          bitIdx: mstReq[m].bitIdx, master: 2'(m)};
      end
    end

    // calibration copy right after reset release
    case (st_r.fsm)
      ST_CAL: begin
        st_nxt.cal[st_r.cnt[1:0]] = psigByte(PS_CAL + 8'(st_r.cnt));
        st_nxt.cnt = st_r.cnt + 10'h001;
        if (st_r.cnt == 10'(CAL_N - 1)) begin
          st_nxt.cnt = '0;
          st_nxt.calDone = 1'b1;
          st_nxt.fsm = ST_IDLE;
        end
      end
      ST_ERASE: begin
        // flash pages go first; user row is never touched here
        st_nxt.flash.pageErase = 1'b1;
        st_nxt.flash.addr = FA_W'({st_r.cnt, {PAGE_LOG{1'b0}}});
        st_nxt.cnt = st_r.cnt + 10'h001;
        if (st_r.cnt == FLASH_PAGES - 10'h001)
          st_nxt.fsm = ST_LOCKCLR;
      end
      ST_LOCKCLR: begin
        st_nxt.lock = LOCK_RST;
        st_nxt.cnt = '0;
        st_nxt.fsm = ST_IDLE;
      end
      default: ;
    endcase

    // program store from the cpu
    if (spmReq.valid) begin
      if (inBoot(spmReq.pc) && st_r.fsm == ST_IDLE &&
          flashWritable(spmReq.addr, st_r.lock)) begin
        st_nxt.flash.wr = 1'b1;
        st_nxt.flash.addr = spmReq.addr;
        st_nxt.flash.data = spmReq.data;
      end else begin
        st_nxt.refused = 1'b1;
      end
    end

    // software register port; psig and fuse writes are dropped
    if (regWr) begin
      case (regAddr)
        REG_CTRL: st_nxt.eeMap = regWdata[CTRL_EEMAP];
        REG_LOCK: st_nxt.lock = st_nxt.lock & regWdata;
        REG_SIGADR: st_nxt.sigAdr = regWdata;
        REG_USIG: if (st_r.fsm != ST_ERASE)
          st_nxt.usig[st_r.sigAdr] = regWdata;
        REG_STAT: if (regWdata[STAT_REFUSED])
          st_nxt.refused = 1'b0;
        REG_CMD: begin
          if (regWdata[CMD_CHIPERASE] && st_r.fsm == ST_IDLE) begin
            st_nxt.fsm = ST_ERASE;
            st_nxt.cnt = '0;
          end
          if (regWdata[CMD_USIGERASE])
            st_nxt.usig = {USIG_BYTES{BYTE_ERASED}};
        end
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL: regRdNxt = {7'h00, st_r.eeMap};
        REG_LOCK: regRdNxt = st_r.lock;
        REG_FUSE: regRdNxt = st_r.fuse;
        REG_STAT: regRdNxt = {6'h00, st_r.refused, st_r.fsm != ST_IDLE};
        REG_SIGADR: regRdNxt = st_r.sigAdr;
        REG_PSIG: regRdNxt = psigByte(st_r.sigAdr);
        REG_USIG: regRdNxt = st_r.usig[st_r.sigAdr];
        default: regRdNxt = 8'h00;
      endcase
    end
    st_nxt.rdata = regRdNxt;

    // programmer port: the only path that writes fuses
    st_nxt.pdiRdata = 8'h00;
    if (pdiReq.valid) begin
      if (pdiReq.write) begin
        case (pdiReq.sel)
          SEL_FUSE: st_nxt.fuse = pdiReq.wdata;
          SEL_LOCK: st_nxt.lock = st_nxt.lock & pdiReq.wdata;
          SEL_USIG: if (st_r.fsm != ST_ERASE)
            st_nxt.usig[pdiReq.addr] = pdiReq.wdata;
          SEL_ERASE: if (st_r.fsm == ST_IDLE) begin
            st_nxt.fsm = ST_ERASE;
            st_nxt.cnt = '0;
          end
          default: ;
        endcase
      end else begin
        case (pdiReq.sel)
          SEL_FUSE: st_nxt.pdiRdata = st_r.fuse;
          SEL_LOCK: st_nxt.pdiRdata = st_r.lock;
          SEL_USIG: st_nxt.pdiRdata = st_r.usig[pdiReq.addr];
          SEL_PSIG: st_nxt.pdiRdata = psigByte(pdiReq.addr);
          default: st_nxt.pdiRdata = 8'h00;
        endcase
      end
    end
    // a refusal in the clearing cycle still sticks
    if (spmReq.valid && !st_nxt.flash.wr)
      st_nxt.refused = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    for (int m = 0; m < NMAST; m++)
      mstStall[m] = mstReq[m].valid && setSel[m] != SET_NONE &&
        !grant[m];
  end
  assign mstGpHit = st_r.gpHit;
  assign mstGpRdata = st_r.gpRd;
  assign mstDecErr = st_r.decErr;
  assign setBus = st_r.bus;
  assign flashOut = st_r.flash;
  assign regRdata = st_r.rdata;
  assign pdiRdata = st_r.pdiRdata;
  assign lockBits = st_r.lock;
  assign fuseBits = st_r.fuse;
  assign calOut = st_r.cal;
  assign calDone = st_r.calDone;

  // checks
  spm_app_refuse_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    spmReq.valid && !inBoot(spmReq.pc) |=> !flashOut.wr && st_r.refused)
    else $error("program store from application section was carried out");

  spm_boot_self_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    spmReq.valid && inBoot(spmReq.pc) && inBoot(spmReq.addr) &&
    st_r.lock[LOCK_BOOT] && st_r.fsm == ST_IDLE
    |=> flashOut.wr && flashOut.addr == $past(spmReq.addr))
    else $error("boot-resident program store to boot section was lost");

  tbl_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    spmReq.valid && spmReq.addr >= APPTBL_START &&
    spmReq.addr < BOOT_START && !st_r.lock[LOCK_TBL] |=> !flashOut.wr)
    else $error("write reached a locked table region");

  lock_strict_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $past(st_r.fsm) != ST_LOCKCLR |-> (st_r.lock & ~$past(st_r.lock)) == 8'h00)
    else $error("a lock bit moved toward looser protection");

  lock_last_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r.fsm == ST_ERASE ##1 st_r.fsm == ST_LOCKCLR
    |=> st_r.lock == LOCK_RST && st_r.fsm == ST_IDLE)
    else $error("locks not released after flash erase");

  fuse_sw_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pdiReq.valid |=> $stable(st_r.fuse))
    else $error("fuse changed without the programmer port");

  usig_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_r.fsm == ST_ERASE && !regWr |=> $stable(st_r.usig))
    else $error("user signature row altered by chip erase");

  arb_prio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mstReq[M_CPU].valid && mstReq[M_DRD].valid &&
    setSel[M_CPU] == setSel[M_DRD] && setSel[M_CPU] != SET_NONE
    |-> !mstStall[M_CPU] && mstStall[M_DRD])
    else $error("priority not given to the cpu");

  short_io_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mstReq[M_CPU].valid && mstReq[M_CPU].op == OP_IO
    |=> st_r.bus[SET_IO].addr <= SHORTIO_END || st_r.gpHit[M_CPU])
    else $error("short io access left the low io range");

  ee_unmapped_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    mstReq[M_DRD].valid && mstReq[M_DRD].addr == EE_START &&
    mstReq[M_DRD].op == OP_DATA && !st_r.eeMap
    |=> st_r.decErr[M_DRD] && !st_r.bus[SET_EE].valid)
    else $error("eeprom window answered while unmapped");

  cal_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(st_r.calDone) |-> st_r.cal == CAL_BYTES)
    else $error("calibration bytes not copied at reset");

  gpio_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mstReq[M_CPU].valid && mstReq[M_CPU].op == OP_DATA &&
    mstReq[M_CPU].addr <= GPIO_END |=> st_r.gpHit[M_CPU])
    else $error("general purpose register access not answered");

  bit_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mstReq[M_CPU].valid && mstReq[M_CPU].op == OP_BITCLR
    |=> st_r.gpHit[M_CPU] || st_r.bus[SET_IO].addr <= BITIO_END)
    else $error("bit operation left the low io range");

  fuse_pdi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pdiReq.valid && pdiReq.write && pdiReq.sel == SEL_FUSE
    |=> st_r.fuse == $past(pdiReq.wdata))
    else $error("programmer fuse write not taken");

  erase_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st_r.fsm == ST_LOCKCLR);
  spm_ok_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    flashOut.wr);
  conflict_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mstStall[M_DWR]);
  parallel_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    &grant);
endmodule // mmnp_top

// >>> mmnp_top_tb.sv
// self-checking bench for the memory map and nvm protection block
`timescale 1ns/1ns
module mmnp_top_tb;
  import mmnp_pkg::*;
  localparam logic [23:0] DEV = 24'h3b7d02; // arbitrary value
  localparam logic [31:0] CAL = 32'h11223344; // arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata, pdiRdata, lockBits, fuseBits, q;
  mmnp_req_type [NMAST-1:0] mstReq;
  logic [NMAST-1:0] mstStall, mstGpHit, mstDecErr;
  logic [NMAST-1:0][7:0] mstGpRdata;
  mmnp_bus_type [NSET-1:0] setBus;
  mmnp_spm_type spmReq = '0;
  mmnp_flash_type flashOut;
  mmnp_pdi_type pdiReq;
  logic [CAL_N-1:0][7:0] calOut;
  logic calDone;
  int failures = 0;
  int n_tests = 0;
  int peCnt = 0;
  int lockEarly = 0;

  always #2 ref_clk = ~ref_clk;

  mmnp_top #(.DEV_ID(DEV), .CAL_BYTES(CAL)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .mstReq(mstReq), .mstStall(mstStall),
    .mstGpHit(mstGpHit), .mstGpRdata(mstGpRdata),
    .mstDecErr(mstDecErr), .setBus(setBus), .spmReq(spmReq),
    .flashOut(flashOut), .pdiReq(pdiReq), .pdiRdata(pdiRdata),
    .lockBits(lockBits), .fuseBits(fuseBits), .calOut(calOut),
    .calDone(calDone));

  mmnp_master_model mdl (.ref_clk(ref_clk), .mstStall(mstStall),
    .pdiRdata(pdiRdata), .mstReq(mstReq), .pdiReq(pdiReq));

  // locks must stay programmed while any page is still erasing
  always @(posedge ref_clk) begin
    if (flashOut.pageErase === 1'b1) begin
      peCnt++;
      if (lockBits === 8'hff) lockEarly++;
    end
  end

  task automatic chk(input logic [39:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask
  task automatic program_store_instruction(input logic [16:0] pc, a, input logic expWr);
    @(posedge ref_clk);
    spmReq <= '{valid: 1'b1, pc: pc, addr: a, data: 16'hbeef};
    @(posedge ref_clk);
    spmReq <= '{valid: 1'b0, pc: ~pc, addr: ~a, data: 16'h2bd3};
    @(negedge ref_clk);
    chk(flashOut.wr, expWr, "store write");
    if (expWr) chk({flashOut.addr, flashOut.data}, {a, 16'hbeef}, "word");
  endtask
  task automatic bus(input int m, input mmnp_op_type op,
      input logic [15:0] a, input logic w, input int s);
    mdl.req(m, op, a, w, 3'h2);
    @(negedge ref_clk);
    chk({setBus[s].valid, setBus[s].addr}, {1'b1, a}, "set routing");
  endtask
  task automatic waitIdle;
    for (int i = 0; i < 800; i++) begin
      rd(REG_STAT, q);
      if (q[STAT_BUSY] === 1'b0) break;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // full chip erase is about 550 cycles, the rest is short
  initial begin
    #40000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(calDone, 1'b1, "cal done");
    chk(calOut, CAL, "cal copy");
    chk({lockBits, fuseBits}, 16'hffff, "nvm reset");
    $display("test reset done");
    wr(REG_FUSE, 8'h00);
    @(negedge ref_clk);
    chk(fuseBits, 8'hff, "sw fuse write");
    mdl.programming_debug_port(SEL_FUSE, 1'b1, 8'h00, 8'hf7, q);
    rd(REG_FUSE, q);
    chk(q, 8'hf7, "fuse value");
    $display("test fuses done");
    wr(REG_SIGADR, PS_ID);
    wr(REG_PSIG, 8'h00);
    rd(REG_PSIG, q);
    chk(q, DEV[7:0], "id byte");
    mdl.programming_debug_port(SEL_PSIG, 1'b1, PS_ID, 8'h00, q);
    mdl.programming_debug_port(SEL_PSIG, 1'b0, PS_ID, 8'h00, q);
    chk(q, DEV[7:0], "pdi id");
    mdl.programming_debug_port(SEL_PSIG, 1'b0, PS_CAL, 8'h00, q);
    chk(q, CAL[7:0], "pdi cal");
    $display("test signature done");
    program_store_instruction(17'h10010, 17'h00100, 1'b1);
    program_store_instruction(17'h00010, 17'h00100, 1'b0);
    rd(REG_STAT, q);
    chk(q[STAT_REFUSED], 1'b1, "refused flag");
    wr(REG_STAT, 8'h02);
    rd(REG_STAT, q);
    chk(q[STAT_REFUSED], 1'b0, "refused clear");
    program_store_instruction(17'h10ffe, 17'h10800, 1'b1);
    wr(REG_LOCK, 8'hfe);
    wr(REG_LOCK, 8'hff);
    rd(REG_LOCK, q);
    chk(q, 8'hfe, "lock stricter");
    program_store_instruction(17'h10000, 17'h0efff, 1'b0);
    program_store_instruction(17'h10000, 17'h0f000, 1'b1);
    $display("test store done");
    bus(0, OP_IO, 16'h0025, 1'b0, SET_IO);
    bus(1, OP_DATA, 16'h0fff, 1'b0, SET_IO);
    bus(2, OP_DATA, 16'h2000, 1'b1, SET_SRAM);
    mdl.req(1, OP_DATA, 16'h1000, 1'b0, 3'h0);
    @(negedge ref_clk);
    chk({mstDecErr[1], setBus[SET_EE].valid}, 2'b10, "map off");
    wr(REG_CTRL, 8'h01);
    bus(2, OP_DATA, 16'h1020, 1'b1, SET_EE);
    mdl.req(0, OP_BITSET, 16'h0005, 1'b1, 3'h2);
    mdl.req(1, OP_DATA, 16'h0005, 1'b0, 3'h0);
    @(negedge ref_clk);
    chk({mstGpHit[1], mstGpRdata[1]}, 9'h104, "gpio bit");
    mdl.req(0, OP_BITCLR, 16'h0005, 1'b1, 3'h2);
    mdl.req(0, OP_DATA, 16'h0005, 1'b0, 3'h0);
    @(negedge ref_clk);
    chk({mstGpHit[0], mstGpRdata[0]}, 9'h100, "gpio clear");
    bus(0, OP_BITSET, 16'h0018, 1'b1, SET_IO);
    $display("test map done");
    fork
      bus(0, OP_DATA, 16'h2010, 1'b0, SET_SRAM);
      mdl.req(1, OP_DATA, 16'h2020, 1'b0, 3'h0);
    join
    chk(mdl.stallCnt[1], 1, "stall once");
    fork
      bus(0, OP_IO, 16'h0030, 1'b0, SET_IO);
      bus(2, OP_DATA, 16'h2004, 1'b1, SET_SRAM);
    join
    chk(mdl.stallCnt[0] + mdl.stallCnt[2], 0, "no stall");
    $display("test arbitration done");
    wr(REG_SIGADR, 8'h03);
    wr(REG_USIG, 8'h3c);
    wr(REG_CMD, 8'h01);
    for (int i = 0; i < 800 && lockBits !== 8'hff; i++)
      @(negedge ref_clk);
    chk(peCnt, FLASH_PAGES, "page erases");
    chk(lockEarly, 0, "lock held");
    waitIdle();
    rd(REG_USIG, q);
    chk(q, 8'h3c, "user row kept");
    wr(REG_CMD, 8'h02);
    waitIdle();
    rd(REG_USIG, q);
    chk(q, BYTE_ERASED, "user row erased");
    $display("test erase done");
    mdl.programming_debug_port(SEL_LOCK, 1'b1, 8'h00, 8'hef, q);
    mdl.programming_debug_port(SEL_LOCK, 1'b1, 8'h00, 8'hff, q);
    mdl.programming_debug_port(SEL_LOCK, 1'b0, 8'h00, 8'h00, q);
    chk(q, 8'hef, "pdi lock");
    mdl.programming_debug_port(SEL_USIG, 1'b1, 8'h03, 8'h77, q);
    rd(REG_USIG, q);
    chk(q, 8'h77, "pdi user row");
    mdl.programming_debug_port(SEL_ERASE, 1'b1, 8'h00, 8'h00, q);
    waitIdle();
    chk(lockBits, 8'hff, "pdi erase");
    rd(REG_USIG, q);
    chk(q, 8'h77, "user row kept by pdi erase");
    $display("test programmer done");
    end_of_test();
  end
endmodule // mmnp_top_tb
